/* File: common/cil_pkg.sv */
// Package: constants, types and register map of the configuration image loader
package cil_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int GAP_NS        = 400;
  localparam int GAP_CYCLES    = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------
  localparam int CFG_WORDS = 64;
  localparam int CFG_AW    = 6;
  localparam int FA_W      = 26;
  localparam int RCP_AW    = 7;

  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [8:0] REG_CTRL   = 9'h000;
  localparam logic [8:0] REG_BASE   = 9'h004;
  localparam logic [8:0] REG_STATUS = 9'h008;
  localparam logic [8:0] REG_RBPTR  = 9'h00C;
  localparam logic [8:0] REG_RBDATA = 9'h010;
  localparam logic [8:0] REG_ERR    = 9'h014;
  localparam int         RCP_SEL    = 8;

  // CTRL fields
  localparam int CTRL_RELOAD  = 0;
  localparam int CTRL_KEYSEL  = 1;
  localparam int CTRL_DECRYPT = 2;
  localparam int CTRL_EXTCLK  = 3;
  // ERR fields
  localparam int ERR_SIZE = 0;
  localparam int ERR_AUTH = 1;

  localparam logic [FA_W-1:0] GOLDEN_BASE = 26'h0000000;

  // ------------------------------------------------------------
  // Mode pin codes and width detection patterns
  // ------------------------------------------------------------
  localparam logic [2:0]  MODE_SER_FLASH = 3'h1;
  localparam logic [2:0]  MODE_PAR_FLASH = 3'h2;
  localparam logic [15:0] DET_X16        = 16'hBB11;
  localparam logic [3:0]  DET_X4         = 4'hB;
  localparam logic [1:0]  DET_X2         = 2'h2;

  typedef enum logic [2:0] {
    W1  = 3'b000,
    W2  = 3'b001,
    W4  = 3'b010,
    W8  = 3'b011,
    W16 = 3'b100,
    W32 = 3'b101
  } cil_width_t;

  typedef enum logic [1:0] {
    L_IDLE = 2'b00,
    L_DET  = 2'b01,
    L_RUN  = 2'b10
  } cil_lstate_t;

  typedef enum logic [2:0] {
    C_GAP  = 3'b000,
    C_HDR  = 3'b001,
    C_DATA = 3'b010,
    C_AUTH = 3'b011,
    C_DONE = 3'b100,
    C_ERR  = 3'b101
  } cil_cstate_t;

  // Image header word
  typedef struct packed {
    logic [15:0] start;
    logic [15:0] count;
  } cil_hdr_t;

  // Status register layout
  typedef struct packed {
    logic [13:0] rsvd;
    logic        err_auth;
    logic        err_size;
    logic [4:0]  rsvd2;
    cil_width_t  width;
    logic        rsvd3;
    logic [2:0]  mode;
    logic        fallback;
    logic        error;
    logic        busy;
    logic        done;
  } cil_status_t;

endpackage

/* File: dv/cil_flash_model.sv */
// Parallel NOR flash model on the link clock
`timescale 1ns/10ps
module cil_flash_model (
  input  wire logic                     clk_in,
  input  wire logic [cil_pkg::FA_W-1:0] addr_in,
  input  wire logic                     rd_in,
  output logic      [15:0]              data_out
);
  logic [15:0] mem [0:255];
  initial data_out = 16'h0;
  // Idle bus toggles so a stale sample never looks valid
  always @(posedge clk_in) begin
    if (rd_in) data_out <= mem[addr_in[7:0]];
    else data_out <= ~data_out;
  end
endmodule

/* File: dv/cil_loader_assertions.sv */
// Checker: port properties of the image loader
`timescale 1ns/10ps
module cil_loader_assertions (
  // Clock, reset, register port
  input wire logic                     CLK_IN,
  input wire logic                     NRST_IN,
  input wire logic [8:0]               REG_ADDR_IN,
  input wire logic                     REG_WR_IN,
  input wire logic                     REG_RD_IN,
  input wire logic [31:0]              REG_RDATA_OUT,
  // Pins and status
  input wire logic                     RESTART_N_IN,
  input wire logic                     DONE_OUT,
  input wire logic                     ERROR_OUT,
  input wire logic                     USER_EN_OUT,
  // Runtime reconfig port
  input wire logic [cil_pkg::RCP_AW-1:0] RCP_ADDR_OUT,
  input wire logic                     RCP_WE_OUT,
  input wire logic                     RCP_EN_OUT,
  input wire logic [31:0]              RCP_RDATA_IN
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);
  AST_USER_EN: assert property (USER_EN_OUT == DONE_OUT) else $error("user enable");
  AST_DONE_ERR: assert property (!(DONE_OUT && ERROR_OUT)) else $error("done and error");
  AST_RCP_EN: assert property (RCP_EN_OUT == (REG_ADDR_IN[8] && (REG_WR_IN || REG_RD_IN)))
    else $error("window enable");
  AST_RCP_WE: assert property (RCP_WE_OUT == (REG_ADDR_IN[8] && REG_WR_IN))
    else $error("window write");
  AST_RCP_ADDR: assert property (RCP_EN_OUT |-> RCP_ADDR_OUT == REG_ADDR_IN[8:2])
    else $error("window address");
  AST_RCP_RD: assert property (REG_RD_IN && REG_ADDR_IN[8] |=> REG_RDATA_OUT == $past(RCP_RDATA_IN))
    else $error("window read data");
  AST_RD_IDLE: assert property (!REG_RD_IN |=> REG_RDATA_OUT == 32'h0) else $error("idle rdata");
  AST_RESTART: assert property (!RESTART_N_IN [*4] |-> !DONE_OUT)
    else $error("done in restart");
  cover property ($rose(DONE_OUT));
  cover property (RCP_WE_OUT);
  cover property ($fell(RESTART_N_IN));
endmodule
bind cil_loader cil_loader_assertions cil_loader_assertions_inst (.CLK_IN, .NRST_IN, .REG_ADDR_IN,
  .REG_WR_IN, .REG_RD_IN, .REG_RDATA_OUT, .RESTART_N_IN, .DONE_OUT, .ERROR_OUT, .USER_EN_OUT,
  .RCP_ADDR_OUT, .RCP_WE_OUT, .RCP_EN_OUT, .RCP_RDATA_IN);

/* File: dv/cil_loader_bench.sv */
// Bench: loads, partial reload, fallback, restart, window, readback
`timescale 1ns/10ps
module cil_loader_bench;
  logic CLK_IN = 0, NRST_IN = 0, REG_WR_IN = 0, REG_RD_IN = 0, RESTART_N_IN = 1, LINK_CLK_IN = 0;
  logic SLV_VALID_IN = 0, CCLK_OUT, CLK_EXT_SEL_OUT, FLASH_RD_OUT, SLV_READY_OUT, DONE_OUT;
  logic ERROR_OUT, USER_EN_OUT, RCP_WE_OUT, RCP_EN_OUT;
  logic [8:0] REG_ADDR_IN = 9'h000;
  logic [2:0] MODE_IN = cil_pkg::MODE_PAR_FLASH;
  logic [31:0] REG_WDATA_IN = 32'h0, SLV_DATA_IN = 32'h0, RCP_RDATA_IN = 32'h0;
  logic [31:0] REG_RDATA_OUT, RCP_WDATA_OUT, d;
  logic [255:0] BBRAM_KEY_IN = 256'h0, FUSE_KEY_IN = 256'h0;
  logic [15:0] FLASH_DATA_IN, lf = 16'h17B2;
  logic [cil_pkg::FA_W-1:0] FLASH_ADDR_OUT;
  logic [6:0] RCP_ADDR_OUT;
  int err_total = 0, n_checks = 0, cyc = 0, exp_cfg [64];
  int qa [$];
  cil_loader cil_loader_inst (.*);
  cil_flash_model cil_flash_model_inst (.clk_in(CCLK_OUT), .addr_in(FLASH_ADDR_OUT),
    .rd_in(FLASH_RD_OUT), .data_out(FLASH_DATA_IN));
  initial forever #50 CLK_IN = ~CLK_IN;
  initial begin
    #3;
    forever #6 LINK_CLK_IN = ~LINK_CLK_IN;
  end
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    n_checks++;
    if (seen !== ex) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, ex, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] v);
    @(posedge CLK_IN);
    REG_ADDR_IN <= a;
    REG_WDATA_IN <= v;
    REG_WR_IN <= 1'b1;
    @(posedge CLK_IN);
    REG_WR_IN <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] a);
    @(posedge CLK_IN);
    lf = nx(lf);
    REG_ADDR_IN <= a;
    REG_RD_IN <= 1'b1;
    RCP_RDATA_IN <= {lf, ~lf};
    @(posedge CLK_IN);
    REG_RD_IN <= 1'b0;
    #1 d = REG_RDATA_OUT;
  endtask
  // Flash image: width tag, header, payload, checksum, high half first
  task automatic img(input int b, input int st, input int n, input int bad);
    logic [31:0] w, s;
    s = 32'h0;
    cil_flash_model_inst.mem[b] = cil_pkg::DET_X16;
    w = {st[15:0], n[15:0]};
    for (int i = 0; i <= n + 1; i++) begin
      if (i > 0 && i <= n) begin
        lf = nx(lf);
        w = {lf, lf ^ 16'h5A5A};
        s = s + w;
        if (bad == 0) exp_cfg[st + i - 1] = w;
        if (b == 0) qa.push_back(w);
      end
      if (i == n + 1) w = s + bad;
      cil_flash_model_inst.mem[b + 1 + 2 * i] = w[31:16];
      cil_flash_model_inst.mem[b + 2 + 2 * i] = w[15:0];
    end
  endtask
  task automatic wt;
    for (int k = 0; k < 20 && DONE_OUT === 1'b1; k++) @(posedge CLK_IN);
    for (int k = 0; k < 3000 && DONE_OUT !== 1'b1; k++) @(posedge CLK_IN);
    chk("done", DONE_OUT, 1'b1);
  endtask
  task automatic rb;
    for (int i = 0; i < 4; i++) begin
      wr(cil_pkg::REG_RBPTR, i);
      rd(cil_pkg::REG_RBDATA);
      chk("cfg", d, exp_cfg[i]);
    end
  endtask
  always @(posedge CLK_IN) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_of_test;
    end
  end
  initial begin
    img(0, 0, 4, 0);
    repeat (12) @(posedge CLK_IN);
    NRST_IN <= 1'b1;
    wt;
    rd(cil_pkg::REG_STATUS);
    chk("status", d[10:0], 11'h421);
    rb;
    img(64, 2, 2, 0);
    wr(cil_pkg::REG_BASE, 32'h40);
    wr(cil_pkg::REG_CTRL, 32'h9);
    wt;
    chk("extclk", CLK_EXT_SEL_OUT, 1'b1);
    rb;
    img(128, 0, 2, 1);
    wr(cil_pkg::REG_BASE, 32'h80);
    wr(cil_pkg::REG_CTRL, 32'h1);
    wt;
    for (int i = 0; i < 4; i++) exp_cfg[i] = qa[i];
    rd(cil_pkg::REG_STATUS);
    chk("fallback", d[3], 1'b1);
    chk("autherr", d[17], 1'b1);
    chk("error", ERROR_OUT, 1'b0);
    rb;
    @(posedge CLK_IN);
    RESTART_N_IN <= 1'b0;
    repeat (4) @(posedge CLK_IN);
    chk("restart", DONE_OUT, 1'b0);
    RESTART_N_IN <= 1'b1;
    wt;
    rb;
    wr(9'h104, {lf, lf});
    chk("wdata", RCP_WDATA_OUT, {lf, lf});
    rd(9'h108);
    chk("window", d, RCP_RDATA_IN);
    rd(9'h01C);
    chk("unmapped", d, 32'h0);
    end_of_test;
  end
endmodule

/* File: rtl/cil_loader.sv */
// Configuration image loader: flash fetch, slave intake, decrypt, load, readback
//
// Operation
// R1: After every reset the loader runs a full image load before enabling the user design.
// R2: Pulling the restart pin low discards the configuration and starts a fresh load.
// R3: The three mode pins choose serial flash, parallel flash or slave intake.
// R4: In master flash modes the loader addresses the flash and reads the image itself.
// R5: The flash data width (1, 2, 4, 8 or 16 bits) is detected from the first sample.
// R6: As master the loader drives the configuration clock, internal or external by choice.
// R7: In slave mode an outside party pushes 32-bit words which the loader accepts.
// R8: Software may reload from another image base in flash with no outside help.
// R9: A failed load of a non-golden image falls back to reloading the golden image.
// R10: Payload words are decrypted on the fly with a 256-bit key and checked on completion.
// R11: The key comes from battery-backed storage or fuses, selected by software.
// R12: Configuration words can be read back while the user design keeps running.
// R13: A header selects the region to write, leaving all other words untouched.
// R14: A register window forwards reads and writes to the runtime reconfig port.
// R15: Done and error are reported on pins and in the status register.
`timescale 1ns/10ps
module cil_loader (
  // Clock and reset
  input  wire logic                     CLK_IN,
  input  wire logic                     NRST_IN,
  // Register port
  input  wire logic [8:0]               REG_ADDR_IN,
  input  wire logic [31:0]              REG_WDATA_IN,
  input  wire logic                     REG_WR_IN,
  input  wire logic                     REG_RD_IN,
  output logic      [31:0]              REG_RDATA_OUT,
  // Device pins
  input  wire logic [2:0]               MODE_IN,
  input  wire logic                     RESTART_N_IN,
  // Key stores
  input  wire logic [255:0]             BBRAM_KEY_IN,
  input  wire logic [255:0]             FUSE_KEY_IN,
  // Link
  input  wire logic                     LINK_CLK_IN,
  output logic                          CCLK_OUT,
  output logic                          CLK_EXT_SEL_OUT,
  output logic      [cil_pkg::FA_W-1:0] FLASH_ADDR_OUT,
  output logic                          FLASH_RD_OUT,
  input  wire logic [15:0]              FLASH_DATA_IN,
  input  wire logic [31:0]              SLV_DATA_IN,
  input  wire logic                     SLV_VALID_IN,
  output logic                          SLV_READY_OUT,
  // Status
  output logic                          DONE_OUT,
  output logic                          ERROR_OUT,
  output logic                          USER_EN_OUT,
  // Runtime reconfig port
  output logic [cil_pkg::RCP_AW-1:0]    RCP_ADDR_OUT,
  output logic [31:0]                   RCP_WDATA_OUT,
  output logic                          RCP_WE_OUT,
  output logic                          RCP_EN_OUT,
  input  wire logic [31:0]              RCP_RDATA_IN
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  cil_pkg::cil_cstate_t    cst;
  cil_pkg::cil_lstate_t    lst;
  cil_pkg::cil_width_t     lwidth;
  cil_pkg::cil_width_t     wid_s1;
  cil_pkg::cil_width_t     wid_s2;
  cil_pkg::cil_hdr_t       hdr;
  cil_pkg::cil_status_t    stat;
  logic [2:0]              mode_s1;
  logic [2:0]              mode_s2;
  logic [2:0]              cur_mode;
  logic [2:0]              lmode;
  logic                    rst_s1;
  logic                    rst_s2;
  logic [cil_pkg::FA_W-1:0] cur_base;
  logic [cil_pkg::FA_W-1:0] img_base;
  logic                    cur_en;
  logic [2:0]              gap_cnt;
  logic                    fallback;
  logic                    key_sel;
  logic                    dec_en;
  logic                    ext_clk;
  logic                    err_size;
  logic                    err_auth;
  logic                    reload_cmd;
  logic                    err_clr_size;
  logic                    err_clr_auth;
  logic [cil_pkg::CFG_AW-1:0] rb_ptr;
  logic [31:0]             cfg_mem [cil_pkg::CFG_WORDS];
  logic [cil_pkg::CFG_AW-1:0] wptr;
  logic [15:0]             left;
  logic [31:0]             sum;
  logic [2:0]              kidx;
  logic [255:0]            key;
  logic [31:0]             plain;
  logic                    hdr_bad;
  logic                    rq_s1;
  logic                    rq_s2;
  logic                    rq_s3;
  logic                    new_word;
  logic                    ack;
  logic                    load_err;
  // Link domain, then register port read data and window hit
  logic                    en_s1;
  logic                    en_s2;
  logic                    ack_s1;
  logic                    ack_s2;
  logic                    req;
  logic                    l_busy;
  logic                    lmaster;
  logic                    rd_d;
  logic [31:0]             sh;
  logic [31:0]             next_sh;
  logic [5:0]              cnt;
  logic [5:0]              wbits;
  logic [31:0]             xw;
  logic [cil_pkg::FA_W-1:0] faddr;
  logic [31:0]             next_rdata;
  logic                    rcp_hit;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic cil_pkg::cil_width_t detect(input logic [15:0] d,
                                                 input logic par);
    cil_pkg::cil_width_t w;
    if (par) begin
      w = (d == cil_pkg::DET_X16) ? cil_pkg::W16 : cil_pkg::W8;
    end else if (d[3:0] == cil_pkg::DET_X4) begin
      w = cil_pkg::W4;
    end else if (d[1:0] == cil_pkg::DET_X2) begin
      w = cil_pkg::W2;
    end else begin
      w = cil_pkg::W1;
    end
    return w;
  endfunction

  // ------------------------------------------------------------
  // Pin and link-domain synchronisers (core clock)
  // ------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      mode_s1 <= 3'h0;
      mode_s2 <= 3'h0;
      rst_s1  <= 1'b1;
      rst_s2  <= 1'b1;
      rq_s1   <= 1'b0;
      rq_s2   <= 1'b0;
      rq_s3   <= 1'b0;
      wid_s1  <= cil_pkg::W1;
      wid_s2  <= cil_pkg::W1;
    end else begin
      mode_s1 <= MODE_IN;
      mode_s2 <= mode_s1;
      rst_s1  <= RESTART_N_IN;
      rst_s2  <= rst_s1;
      rq_s1   <= req;
      rq_s2   <= rq_s1;
      rq_s3   <= rq_s2;
      // Width is held steady once detected, so a plain level sync is enough
      wid_s1  <= lwidth;
      wid_s2  <= wid_s1;
    end
  end

  assign new_word = rq_s2 ^ rq_s3;

  // ------------------------------------------------------------
  // Load sequencing (core clock)
  // ------------------------------------------------------------
  assign key   = key_sel ? FUSE_KEY_IN : BBRAM_KEY_IN;                        // [R11]
  assign plain = dec_en ? (xw ^ key[{kidx, 5'h00} +: 32]) : xw;               // [R10]
  assign hdr_bad = ({16'h0000, xw[31:16]} + {16'h0000, xw[15:0]}
                    > 32'(cil_pkg::CFG_WORDS)) || (xw[15:0] == 16'h0000);
  assign load_err = new_word && (((cst == cil_pkg::C_HDR) && hdr_bad)
                    || ((cst == cil_pkg::C_AUTH) && (xw != sum)));

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      cst      <= cil_pkg::C_GAP;                                             // [R1]
      cur_en   <= 1'b0;
      gap_cnt  <= 3'h0;
      cur_base <= cil_pkg::GOLDEN_BASE;
      cur_mode <= 3'h0;
      fallback <= 1'b0;
      hdr      <= '0;
      wptr     <= '0;
      left     <= 16'h0000;
      sum      <= 32'h00000000;
      kidx     <= 3'h0;
    end else if (!rst_s2) begin
      cst     <= cil_pkg::C_GAP;                                              // [R2]
      cur_en  <= 1'b0;
      gap_cnt <= 3'h0;
    end else if (reload_cmd) begin
      cst      <= cil_pkg::C_GAP;                                             // [R8]
      cur_en   <= 1'b0;
      gap_cnt  <= 3'h0;
      cur_base <= img_base;
      fallback <= 1'b0;
    end else if (load_err) begin
      cur_en  <= 1'b0;
      gap_cnt <= 3'h0;
      if (cur_base != cil_pkg::GOLDEN_BASE) begin
        cst      <= cil_pkg::C_GAP;                                           // [R9]
        cur_base <= cil_pkg::GOLDEN_BASE;
        fallback <= 1'b1;
      end else begin
        cst <= cil_pkg::C_ERR;                                                // [R15]
      end
    end else begin
      unique case (cst)
        cil_pkg::C_GAP: begin
          // Link must see enable low before a new load starts
          if (gap_cnt == 3'(cil_pkg::GAP_CYCLES - 1)) begin
            cst      <= cil_pkg::C_HDR;
            cur_en   <= 1'b1;
            cur_mode <= mode_s2;                                              // [R3]
          end else begin
            gap_cnt <= gap_cnt + 3'h1;
          end
        end
        cil_pkg::C_HDR: begin
          if (new_word) begin
            hdr  <= xw;
            wptr <= xw[cil_pkg::CFG_AW-1+16:16];                              // [R13]
            left <= xw[15:0];
            sum  <= 32'h00000000;
            kidx <= 3'h0;
            cst  <= cil_pkg::C_DATA;
          end
        end
        cil_pkg::C_DATA: begin
          if (new_word) begin
            wptr <= wptr + 1'b1;
            sum  <= sum + plain;
            kidx <= kidx + 3'h1;
            left <= left - 16'h0001;
            if (left == 16'h0001) begin
              cst <= cil_pkg::C_AUTH;
            end
          end
        end
        cil_pkg::C_AUTH: begin
          if (new_word) begin
            cst    <= cil_pkg::C_DONE;                                        // [R10]
            cur_en <= 1'b0;
          end
        end
        cil_pkg::C_DONE: begin
          cur_en <= 1'b0;
        end
        default: begin
          cur_en <= 1'b0;
        end
      endcase
    end
  end

  // Every word is acknowledged so the link never hangs on a stale one
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ack <= 1'b0;
    end else if (new_word) begin
      ack <= ~ack;
    end
  end

  // Config memory has no reset; readback only reads it
  always_ff @(posedge CLK_IN) begin
    if (new_word && (cst == cil_pkg::C_DATA) && rst_s2 && !reload_cmd) begin
      cfg_mem[wptr] <= plain;                                                 // [R13]
    end
  end

  // ------------------------------------------------------------
  // Sticky errors: a new error wins over a clear
  // ------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      err_size <= 1'b0;
      err_auth <= 1'b0;
    end else begin
      if (load_err && (cst == cil_pkg::C_HDR)) begin
        err_size <= 1'b1;                                                     // [R15]
      end else if (err_clr_size) begin
        err_size <= 1'b0;
      end
      if (load_err && (cst == cil_pkg::C_AUTH)) begin
        err_auth <= 1'b1;                                                     // [R15]
      end else if (err_clr_auth) begin
        err_auth <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Register port
  // ------------------------------------------------------------
  assign rcp_hit      = REG_ADDR_IN[cil_pkg::RCP_SEL];
  assign reload_cmd   = REG_WR_IN && (REG_ADDR_IN == cil_pkg::REG_CTRL)
                        && REG_WDATA_IN[cil_pkg::CTRL_RELOAD];
  assign err_clr_size = REG_WR_IN && (REG_ADDR_IN == cil_pkg::REG_ERR)
                        && REG_WDATA_IN[cil_pkg::ERR_SIZE];
  assign err_clr_auth = REG_WR_IN && (REG_ADDR_IN == cil_pkg::REG_ERR)
                        && REG_WDATA_IN[cil_pkg::ERR_AUTH];

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      key_sel  <= 1'b0;
      dec_en   <= 1'b0;
      ext_clk  <= 1'b0;
      img_base <= cil_pkg::GOLDEN_BASE;
      rb_ptr   <= '0;
    end else if (REG_WR_IN) begin
      if (REG_ADDR_IN == cil_pkg::REG_CTRL) begin
        key_sel <= REG_WDATA_IN[cil_pkg::CTRL_KEYSEL];                        // [R11]
        dec_en  <= REG_WDATA_IN[cil_pkg::CTRL_DECRYPT];
        ext_clk <= REG_WDATA_IN[cil_pkg::CTRL_EXTCLK];                        // [R6]
      end
      if (REG_ADDR_IN == cil_pkg::REG_BASE) begin
        img_base <= REG_WDATA_IN[cil_pkg::FA_W-1:0];                          // [R8]
      end
      if (REG_ADDR_IN == cil_pkg::REG_RBPTR) begin
        rb_ptr <= REG_WDATA_IN[cil_pkg::CFG_AW-1:0];
      end
    end
  end

  always_comb begin
    stat          = '0;
    stat.done     = (cst == cil_pkg::C_DONE);
    stat.busy     = (cst != cil_pkg::C_DONE) && (cst != cil_pkg::C_ERR);
    stat.error    = (cst == cil_pkg::C_ERR);
    stat.fallback = fallback;
    stat.mode     = cur_mode;
    stat.width    = wid_s2;
    stat.err_size = err_size;
    stat.err_auth = err_auth;
  end

  always_comb begin
    next_rdata = 32'h00000000;
    if (rcp_hit) begin
      next_rdata = RCP_RDATA_IN;                                              // [R14]
    end else begin
      unique case (REG_ADDR_IN)
        cil_pkg::REG_CTRL:   next_rdata = {28'h0000000, ext_clk, dec_en, key_sel, 1'b0};
        cil_pkg::REG_BASE:   next_rdata = {6'h00, img_base};
        cil_pkg::REG_STATUS: next_rdata = stat;                               // [R15]
        cil_pkg::REG_RBPTR:  next_rdata = {26'h0000000, rb_ptr};
        cil_pkg::REG_RBDATA: next_rdata = cfg_mem[rb_ptr];                    // [R12]
        cil_pkg::REG_ERR:    next_rdata = {30'h00000000, err_auth, err_size};
        default:             next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      REG_RDATA_OUT <= 32'h00000000;
    end else begin
      REG_RDATA_OUT <= REG_RD_IN ? next_rdata : 32'h00000000;
    end
  end

  // Window straight to the target; it answers in the strobe cycle
  assign RCP_EN_OUT    = rcp_hit && (REG_RD_IN || REG_WR_IN);                 // [R14]
  assign RCP_WE_OUT    = rcp_hit && REG_WR_IN;
  assign RCP_ADDR_OUT  = REG_ADDR_IN[cil_pkg::RCP_AW+1:2];
  assign RCP_WDATA_OUT = REG_WDATA_IN;

  // ------------------------------------------------------------
  // Status outputs
  // ------------------------------------------------------------
  assign DONE_OUT        = stat.done;                                         // [R15]
  assign ERROR_OUT       = stat.error;
  assign USER_EN_OUT     = stat.done;                                         // [R1]
  assign CLK_EXT_SEL_OUT = ext_clk;                                           // [R6]
  assign CCLK_OUT        = LINK_CLK_IN;                                       // [R6]

  // ------------------------------------------------------------
  // Link domain
  // ------------------------------------------------------------
  always_ff @(posedge LINK_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      en_s1  <= 1'b0;
      en_s2  <= 1'b0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      en_s1  <= cur_en;
      en_s2  <= en_s1;
      ack_s1 <= ack;
      ack_s2 <= ack_s1;
    end
  end

  assign l_busy  = req ^ ack_s2;
  assign lmaster = (lmode == cil_pkg::MODE_SER_FLASH)
                   || (lmode == cil_pkg::MODE_PAR_FLASH);
  // One sample every other edge keeps a finished word from overrunning
  assign FLASH_RD_OUT  = en_s2 && (lst != cil_pkg::L_IDLE) && lmaster
                         && !l_busy && !rd_d;                                 // [R4]
  assign SLV_READY_OUT = en_s2 && (lst == cil_pkg::L_RUN) && !lmaster
                         && !l_busy;                                          // [R7]
  assign FLASH_ADDR_OUT = faddr;

  always_ff @(posedge LINK_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      lst    <= cil_pkg::L_IDLE;
      lmode  <= 3'h0;
      lwidth <= cil_pkg::W1;
    end else if (!en_s2) begin
      lst <= cil_pkg::L_IDLE;
    end else begin
      unique case (lst)
        cil_pkg::L_IDLE: begin
          // Mode and base are held by the core while enable is high
          lmode <= cur_mode;
          if ((cur_mode == cil_pkg::MODE_SER_FLASH)
              || (cur_mode == cil_pkg::MODE_PAR_FLASH)) begin
            lst <= cil_pkg::L_DET;
          end else begin
            lst    <= cil_pkg::L_RUN;
            lwidth <= cil_pkg::W32;                                           // [R7]
          end
        end
        cil_pkg::L_DET: begin
          if (rd_d) begin
            lwidth <= detect(FLASH_DATA_IN,
                             lmode == cil_pkg::MODE_PAR_FLASH);               // [R5]
            lst    <= cil_pkg::L_RUN;
          end
        end
        cil_pkg::L_RUN: begin
          lst <= cil_pkg::L_RUN;
        end
        default: begin
          lst <= cil_pkg::L_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    unique case (lwidth)
      cil_pkg::W1:  begin next_sh = {sh[30:0], FLASH_DATA_IN[0]};    wbits = 6'h01; end
      cil_pkg::W2:  begin next_sh = {sh[29:0], FLASH_DATA_IN[1:0]};  wbits = 6'h02; end
      cil_pkg::W4:  begin next_sh = {sh[27:0], FLASH_DATA_IN[3:0]};  wbits = 6'h04; end
      cil_pkg::W8:  begin next_sh = {sh[23:0], FLASH_DATA_IN[7:0]};  wbits = 6'h08; end
      cil_pkg::W16: begin next_sh = {sh[15:0], FLASH_DATA_IN[15:0]}; wbits = 6'h10; end
      default:      begin next_sh = sh;                              wbits = 6'h20; end
    endcase
  end

  always_ff @(posedge LINK_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rd_d  <= 1'b0;
      sh    <= 32'h00000000;
      cnt   <= 6'h00;
      xw    <= 32'h00000000;
      req   <= 1'b0;
      faddr <= cil_pkg::GOLDEN_BASE;
    end else begin
      rd_d <= FLASH_RD_OUT;
      if (lst == cil_pkg::L_IDLE) begin
        faddr <= cur_base;                                                    // [R8]
        cnt   <= 6'h00;
      end else if (FLASH_RD_OUT) begin
        faddr <= faddr + 1'b1;                                                // [R4]
      end
      if ((lst == cil_pkg::L_RUN) && rd_d && lmaster) begin
        sh <= next_sh;                                                        // [R5]
        if (cnt + wbits == 6'h20) begin
          xw  <= next_sh;
          req <= ~req;
          cnt <= 6'h00;
        end else begin
          cnt <= cnt + wbits;
        end
      end
      if (SLV_READY_OUT && SLV_VALID_IN) begin
        xw  <= SLV_DATA_IN;                                                   // [R7]
        req <= ~req;
      end
    end
  end

endmodule
